// File: frec_ctrl.v
/*
  Flash self-programming controller: table reads into a latch, two-key
  unlock tracking, sector erase with timer, error and done flags.
  Assumes a processor core on a plain register port that halts while
  cpu_stall is high, and a flash array that returns the word in the same cycle as flash_rd.
*/
// Operation
// - Table read fetches one byte at the table pointer into the latch.
// - Core stalled during table read; latch valid next instruction cycle.
// - Pointer bit 0 picks high or low byte of the 16-bit word.
// - Protected operations run only after a completed unlock sequence.
// - Single write unlocks with keys 55h then AAh, then its go bit.
// - Sector erase unlocks with keys CCh then 33h, then wipe go bit.
// - Sector program uses DDh,22h; sector fetch BBh,44h; own pair only.
// - Tracking starts at first key write; steps in back-to-back cycles.
// - Interrupt or debug halt during the steps cancels the operation.
// - Program flash operations stall the core from go until completion.
// - Smallest erase unit is one 128-word sector; no word erase.
// - Erase sector from target bits 21:8; bits 7:0 masked off.
// - Internal timer ends the erase; execution halted throughout.
// - Protected target clears wipe go, skips erase, sets error flag.
// - Wipe go with target outside memory map sets error, no erase.
// - Erase end clears wipe go, sets done; interrupt only if enabled.
// - Erase leaves holding registers and nvm enable unchanged.
// - Write or erase cut short by unexpected event sets error flag.
// - Table pointer is 22 bits from three bytes; top bit is ID space.
`timescale 1ns/1ps
`default_nettype none
`include "frec_regs.vh"

module frec_ctrl #(
  parameter [20:0] ERASE_CYCLES = `FREC_ERASE_TIME_US * `FREC_CLK_MHZ
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // Core status
  input wire irq_taken,
  input wire debug_halt,
  input wire abort_event,
  output reg cpu_stall,
  output reg done_irq,
  // Flash array
  input wire target_protected,
  input wire [15:0] flash_rdata,
  output reg flash_rd,
  output reg [20:0] flash_addr,
  output reg flash_erase,
  output reg [13:0] erase_sector
);

  // Main sequencer states
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_TRD = 3'b010;
  localparam [2:0] S_ERASE = 3'b100;
  // Unlock tracker states
  localparam [2:0] U_IDLE = 3'b001;
  localparam [2:0] U_KEY1 = 3'b010;
  localparam [2:0] U_ARMED = 3'b100;

  reg [2:0] state;
  reg [2:0] ustate;
  reg [1:0] uop;
  reg [21:0] table_pointer;
  reg [7:0] table_latch;
  reg [21:0] nvm_target_address;
  reg nvm_enable;
  reg nvm_done_irq_enable;
  reg nvm_done_flag;
  reg nvm_error_flag;
  reg [3:0] op_go;
  reg [1:0] trd_mode;
  reg trd_hi;
  reg [20:0] timer;
  reg set_done;
  reg set_err;

  wire wr_key = wr && (addr == `FREC_A_KEY);
  wire wr_op = wr && (addr == `FREC_A_OPCTL);
  wire wr_ctl = wr && (addr == `FREC_A_NVMCTL);
  wire disturb = irq_taken || debug_halt;

  // Returns {valid, op index} for a first key
  function [2:0] first_key;
    input [7:0] k;
    begin
      case (k)
        `FREC_KEY_SINGLE_1: first_key = {1'b1, 2'd`FREC_B_SINGLE_GO};
        `FREC_KEY_SPROG_1: first_key = {1'b1, 2'd`FREC_B_SEC_PROG_GO};
        `FREC_KEY_WIPE_1: first_key = {1'b1, 2'd`FREC_B_SEC_WIPE_GO};
        `FREC_KEY_FETCH_1: first_key = {1'b1, 2'd`FREC_B_SEC_FETCH_GO};
        default: first_key = 3'b000;
      endcase
    end
  endfunction

  // Second key belonging to each operation
  function [7:0] second_key;
    input [1:0] op;
    begin
      case (op)
        2'd`FREC_B_SINGLE_GO: second_key = `FREC_KEY_SINGLE_2;
        2'd`FREC_B_SEC_PROG_GO: second_key = `FREC_KEY_SPROG_2;
        2'd`FREC_B_SEC_WIPE_GO: second_key = `FREC_KEY_WIPE_2;
        default: second_key = `FREC_KEY_FETCH_2;
      endcase
    end
  endfunction

  // Go write accepted only in the cycle right after the second key
  // unlocked go
  wire go_unlocked = (ustate == U_ARMED) && wr_op && wdata[uop] && !disturb;
  wire wipe_go = go_unlocked && (uop == 2'd`FREC_B_SEC_WIPE_GO) && nvm_enable && (state == S_IDLE);
  wire tgt_invalid = (nvm_target_address[21:`FREC_PFM_TOP_BIT] != 5'h00);
  wire [21:0] ptr_inc = {table_pointer[21], table_pointer[20:0] + 21'h00_0001};
  wire [21:0] ptr_dec = {table_pointer[21], table_pointer[20:0] - 21'h00_0001};

  // Unlock tracker
  always @(posedge clk) begin
    if (!rst_n) begin
      ustate <= U_IDLE;
      uop <= 2'b00;
    end else if (ce) begin
      case (ustate)
        U_IDLE: begin
          if (wr_key && first_key(wdata) != 3'b000 && !disturb) begin
            ustate <= U_KEY1;
            uop <= first_key(wdata)[1:0];
          end
        end
        U_KEY1: begin
          if (wr_key && wdata == second_key(uop) && !disturb) begin
            ustate <= U_ARMED;
          end else if (wr_key && first_key(wdata) != 3'b000 && !disturb) begin
            ustate <= U_KEY1;
            uop <= first_key(wdata)[1:0];
          end else begin
            ustate <= U_IDLE;
          end
        end
        U_ARMED: ustate <= U_IDLE;
        default: ustate <= U_IDLE;
      endcase
    end
  end

  // Sequencer, registers and flash strobes
  always @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      table_pointer <= `FREC_RST_PTR;
      table_latch <= `FREC_RST_BYTE;
      nvm_target_address <= `FREC_RST_PTR;
      nvm_enable <= 1'b0;
      nvm_done_irq_enable <= 1'b0;
      nvm_done_flag <= 1'b0;
      nvm_error_flag <= 1'b0;
      op_go <= 4'h0;
      trd_mode <= `FREC_TRD_KEEP;
      trd_hi <= 1'b0;
      timer <= 21'h00_0000;
      cpu_stall <= 1'b0;
      flash_rd <= 1'b0;
      flash_addr <= 21'h00_0000;
      flash_erase <= 1'b0;
      erase_sector <= 14'h0000;
      rdata <= `FREC_RST_BYTE;
      done_irq <= 1'b0;
    end else if (ce) begin
      flash_rd <= 1'b0;
      rdata <= `FREC_RST_BYTE;
      if (rd) begin
        case (addr)
          `FREC_A_PTR_LO: rdata <= table_pointer[7:0];
          `FREC_A_PTR_HI: rdata <= table_pointer[15:8];
          `FREC_A_PTR_UP: rdata <= {2'b00, table_pointer[21:16]};
          `FREC_A_LATCH: rdata <= table_latch;
          `FREC_A_NVMCTL: rdata <= {nvm_enable, nvm_done_irq_enable, nvm_done_flag, nvm_error_flag, 3'b000,
                                    state != S_IDLE};
          `FREC_A_OPCTL: rdata <= {4'h0, op_go};
          `FREC_A_TGT_LO: rdata <= nvm_target_address[7:0];
          `FREC_A_TGT_HI: rdata <= nvm_target_address[15:8];
          `FREC_A_TGT_UP: rdata <= {2'b00, nvm_target_address[21:16]};
          default: rdata <= `FREC_RST_BYTE;
        endcase
      end
      if (wr && state == S_IDLE) begin
        case (addr)
          `FREC_A_PTR_LO: table_pointer[7:0] <= wdata;
          `FREC_A_PTR_HI: table_pointer[15:8] <= wdata;
          `FREC_A_PTR_UP: table_pointer[21:16] <= wdata[5:0];
          `FREC_A_LATCH: table_latch <= wdata;
          `FREC_A_TGT_LO: nvm_target_address[7:0] <= wdata;
          `FREC_A_TGT_HI: nvm_target_address[15:8] <= wdata;
          `FREC_A_TGT_UP: nvm_target_address[21:16] <= wdata[5:0];
          `FREC_A_NVMCTL: begin
            nvm_enable <= wdata[`FREC_B_NVM_EN];
            nvm_done_irq_enable <= wdata[`FREC_B_DONE_IE];
          end
          default: ;
        endcase
      end
      // Flags: software clears by writing zero; a set in the same cycle wins
      if (wr_ctl && !wdata[`FREC_B_DONE])
        nvm_done_flag <= 1'b0;
      if (wr_ctl && !wdata[`FREC_B_ERR])
        nvm_error_flag <= 1'b0;
      if (set_done)
        nvm_done_flag <= 1'b1;
      if (set_err)
        nvm_error_flag <= 1'b1;
      done_irq <= (nvm_done_flag || set_done) && nvm_done_irq_enable;
      case (state)
        S_IDLE: begin
          if (wr && addr == `FREC_A_TRD) begin
            state <= S_TRD;
            cpu_stall <= 1'b1;
            flash_rd <= 1'b1;
            trd_mode <= wdata[1:0];
            if (wdata[1:0] == `FREC_TRD_PREINC) begin
              flash_addr <= ptr_inc[21:1];
              trd_hi <= ptr_inc[0];
              table_pointer <= ptr_inc;
            end else begin
              flash_addr <= table_pointer[21:1];
              trd_hi <= table_pointer[0];
            end
          end else if (wipe_go && !target_protected && !tgt_invalid) begin
            state <= S_ERASE;
            op_go[`FREC_B_SEC_WIPE_GO] <= 1'b1;
            cpu_stall <= 1'b1;
            flash_erase <= 1'b1;
            erase_sector <= nvm_target_address[21:8];
            timer <= ERASE_CYCLES;
          end
        end
        S_TRD: begin
          table_latch <= trd_hi ? flash_rdata[15:8] : flash_rdata[7:0];
          if (trd_mode == `FREC_TRD_POSTINC)
            table_pointer <= ptr_inc;
          else if (trd_mode == `FREC_TRD_POSTDEC)
            table_pointer <= ptr_dec;
          cpu_stall <= 1'b0;
          state <= S_IDLE;
        end
        S_ERASE: begin
          timer <= timer - 21'h00_0001;
          if (abort_event || timer == 21'h00_0001) begin
            op_go[`FREC_B_SEC_WIPE_GO] <= 1'b0;
            cpu_stall <= 1'b0;
            flash_erase <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Flag set events, combinational so the set can win over a clear
  always @* begin
    set_done = 1'b0;
    set_err = 1'b0;
    if (state == S_IDLE && !(wr && addr == `FREC_A_TRD) && wipe_go && (target_protected || tgt_invalid))
      set_err = 1'b1;
    if (state == S_ERASE && abort_event)
      set_err = 1'b1;
    else if (state == S_ERASE && timer == 21'h00_0001)
      set_done = 1'b1;
  end

endmodule // frec_ctrl
`default_nettype wire

// File: frec_ctrl_monitor.sv
/* Port checker for frec_ctrl, bound into every instance.
   Assumes ce stays high and the register map of frec_regs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "frec_regs.vh"
module frec_ctrl_monitor #(
  parameter [20:0] ERASE_CYCLES = 21'h14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Core and flash side
  input wire logic irq_taken,
  input wire logic debug_halt,
  input wire logic abort_event,
  input wire logic target_protected,
  input wire logic cpu_stall,
  input wire logic flash_rd,
  input wire logic flash_erase,
  input wire logic [13:0] erase_sector
);
  wire calm = !irq_taken && !debug_halt;
  wire key1 = wr && addr == `FREC_A_KEY && wdata == `FREC_KEY_WIPE_1 && calm;
  wire key2 = wr && addr == `FREC_A_KEY && wdata == `FREC_KEY_WIPE_2 && calm;
  wire go = wr && addr == `FREC_A_OPCTL && wdata[`FREC_B_SEC_WIPE_GO] && calm;
  logic [20:0] erase_cnt;
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the erase so far, judged when it ends
  always @(posedge clk) begin
    if (!rst_n || !flash_erase) begin
      erase_cnt <= 21'h0;
    end else begin
      erase_cnt <= erase_cnt + 21'h1;
    end
  end
  sequence trd_cmd_s;
    wr && addr == `FREC_A_TRD && !cpu_stall;
  endsequence
  sequence trd_walk_s;
    flash_rd && cpu_stall ##1 !flash_rd && !cpu_stall;
  endsequence
  sequence wipe_try_s;
    key1 ##1 key2 ##1 go;
  endsequence
  table_read_a: assert property (trd_cmd_s |=> trd_walk_s)
    else $error("table read walk wrong");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  erase_unlock_a: assert property ($rose(flash_erase) |-> $past(go) && $past(key2, 2) && $past(key1, 3))
    else $error("erase without unlock");
  protect_skip_a: assert property (wipe_try_s ##0 target_protected |=> !flash_erase)
    else $error("protected sector erased");
  map_check_a: assert property ($rose(flash_erase) |-> erase_sector[13:9] == 5'h00)
    else $error("erase outside the map");
  erase_stall_a: assert property (flash_erase |-> cpu_stall)
    else $error("core runs during erase");
  erase_length_a: assert property ($fell(flash_erase) && !$past(abort_event) |-> erase_cnt == ERASE_CYCLES)
    else $error("erase length wrong");
  abort_end_a: assert property (flash_erase && abort_event |=> !flash_erase)
    else $error("erase not cut short");
  sector_hold_a: assert property (flash_erase && $past(flash_erase) |-> $stable(erase_sector))
    else $error("sector moved during erase");
endmodule // frec_ctrl_monitor
bind frec_ctrl frec_ctrl_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) frec_ctrl_monitor_i (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_taken(irq_taken), .debug_halt(debug_halt),
  .abort_event(abort_event), .target_protected(target_protected), .cpu_stall(cpu_stall), .flash_rd(flash_rd),
  .flash_erase(flash_erase), .erase_sector(erase_sector));
`default_nettype wire

// File: frec_flash_model.sv
/* Flash array model answering word reads from the controller.
   Assumes one word request per flash_rd pulse on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module frec_flash_model (
  // Clock
  input wire logic clk,
  // Word read
  input wire logic flash_rd,
  input wire logic [20:0] flash_addr,
  output logic [15:0] flash_rdata
);
  // one word per request
  // The word stands beside flash_rd, so the controller takes it at the edge that ends the pulse
  always @* begin
    if (flash_rd) begin
      flash_rdata = {flash_addr[12:5], ~flash_addr[7:0]};
    end else begin
      // Not held after the answer, so a late sample sees wrong data
      flash_rdata = ~{flash_addr[12:5], ~flash_addr[7:0]};
    end
  end
endmodule // frec_flash_model
`default_nettype wire

// File: frec_regs.vh
/*
  Register offsets, field positions, reset values, key codes and timing
  constants for the flash read, unlock and erase controller.
  Assumes inclusion by bare name from the controller source.
*/
`ifndef FREC_REGS_VH
`define FREC_REGS_VH

// Register indices on the 4-bit register port
`define FREC_A_PTR_LO 4'h0
`define FREC_A_PTR_HI 4'h1
`define FREC_A_PTR_UP 4'h2
`define FREC_A_LATCH 4'h3
`define FREC_A_NVMCTL 4'h4
`define FREC_A_OPCTL 4'h5
`define FREC_A_KEY 4'h6
`define FREC_A_TGT_LO 4'h7
`define FREC_A_TGT_HI 4'h8
`define FREC_A_TGT_UP 4'h9
`define FREC_A_TRD 4'hA

// nvm_control_register fields
`define FREC_B_NVM_EN 7
`define FREC_B_DONE_IE 6
`define FREC_B_DONE 5
`define FREC_B_ERR 4
`define FREC_B_BUSY 0

// operation_control_register fields
`define FREC_B_SINGLE_GO 0
`define FREC_B_SEC_PROG_GO 1
`define FREC_B_SEC_WIPE_GO 2
`define FREC_B_SEC_FETCH_GO 3

// Table read pointer modes
`define FREC_TRD_KEEP 2'b00
`define FREC_TRD_POSTINC 2'b01
`define FREC_TRD_POSTDEC 2'b10
`define FREC_TRD_PREINC 2'b11

// Unlock key codes
`define FREC_KEY_SINGLE_1 8'h55
`define FREC_KEY_SINGLE_2 8'hAA
`define FREC_KEY_SPROG_1 8'hDD
`define FREC_KEY_SPROG_2 8'h22
`define FREC_KEY_WIPE_1 8'hCC
`define FREC_KEY_WIPE_2 8'h33
`define FREC_KEY_FETCH_1 8'hBB
`define FREC_KEY_FETCH_2 8'h44

// Reset values
`define FREC_RST_BYTE 8'h00
`define FREC_RST_PTR 22'h00_0000

// Program flash: 65536 words, byte addresses below 2^17 are valid
`define FREC_PFM_TOP_BIT 17
`define FREC_ID_SPACE_BIT 21

// Erase timing
`define FREC_CLK_MHZ 125
`define FREC_ERASE_TIME_US 10000

`endif

// File: tb_top.sv
/* Self-checking bench for frec_ctrl: table reads, unlock and erase.
   Assumes the flash model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "frec_regs.vh"
module tb_top;
  logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, irq_taken = 0, debug_halt = 0, abort_event = 0;
  logic target_protected = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [21:0] p, q, t;
  logic [1:0] m;
  wire [7:0] rdata;
  wire [15:0] flash_rdata;
  wire [20:0] flash_addr;
  wire [13:0] erase_sector;
  wire cpu_stall, done_irq, flash_rd, flash_erase;
  integer mismatches = 0, samples_checked = 0, seed = 78, i, n;
  always #4 clk = ~clk;
  frec_ctrl #(.ERASE_CYCLES(21'h14)) frec_ctrl_i (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_taken(irq_taken), .debug_halt(debug_halt), .abort_event(abort_event),
    .cpu_stall(cpu_stall), .done_irq(done_irq), .target_protected(target_protected), .flash_rdata(flash_rdata),
    .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_erase(flash_erase), .erase_sector(erase_sector));
  frec_flash_model frec_flash_model_i (.clk(clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata));
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Strobe stays up so writes can follow back to back
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, e);
  endtask
  function automatic logic [7:0] byte_at(input logic [21:0] a);
    logic [15:0] w;
    w = {a[13:6], ~a[8:1]};
    return a[0] ? w[15:8] : w[7:0];
  endfunction
  function automatic logic [21:0] step(input logic [21:0] a, input logic [1:0] md);
    if (md == `FREC_TRD_POSTDEC) return {a[21], a[20:0] - 21'h1};
    if (md == `FREC_TRD_KEEP) return a;
    return {a[21], a[20:0] + 21'h1};
  endfunction
  // Options: 0 irq, 1 halt, 2 gap, 3 protected, 4 abort
  task automatic trial(input logic [7:0] k1, k2, ctl, input logic [4:0] opt, input logic [5:0] up,
    input logic [7:0] ectl);
    t = {up, 16'($random(seed))};
    target_protected <= opt[3];
    wreg(`FREC_A_NVMCTL, ctl);
    wreg(`FREC_A_TGT_LO, t[7:0]);
    wreg(`FREC_A_TGT_HI, t[15:8]);
    wreg(`FREC_A_TGT_UP, {2'b00, t[21:16]});
    // interrupts held off unless the scenario disturbs the sequence
    wreg(`FREC_A_KEY, k1);
    irq_taken <= opt[0];
    debug_halt <= opt[1];
    if (opt[2]) idle;
    wreg(`FREC_A_KEY, k2);
    irq_taken <= 1'b0;
    debug_halt <= 1'b0;
    wreg(`FREC_A_OPCTL, 8'h04);
    idle;
    @(posedge clk);
    #1 check("erase", flash_erase, ectl[5] | opt[4]);
    if (ectl[5] | opt[4]) check("sector", erase_sector, t[21:8]);
    if (opt[4]) begin
      @(posedge clk);
      abort_event <= 1'b1;
      @(posedge clk);
      abort_event <= 1'b0;
    end
    for (n = 0; n < 64 && flash_erase; n++) @(posedge clk);
    rreg(`FREC_A_NVMCTL, ectl);
    rreg(`FREC_A_OPCTL, 8'h00);
    check("done irq", done_irq, ectl[5] & ectl[6]);
    target_protected <= 1'b0;
  endtask
  task automatic complete_run;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) rreg(4'(i), 8'h00);
    for (i = 0; i < 8; i++) begin
      p = (i == 0) ? 22'h3f_ffff : 22'($random(seed));
      m = 2'(i + 1);
      wreg(`FREC_A_PTR_LO, p[7:0]);
      wreg(`FREC_A_PTR_HI, p[15:8]);
      wreg(`FREC_A_PTR_UP, {2'b00, p[21:16]});
      wreg(`FREC_A_TRD, {6'h00, m});
      q = step(p, m);
      idle;
      rreg(`FREC_A_LATCH, byte_at((m == `FREC_TRD_PREINC) ? q : p));
      rreg(`FREC_A_PTR_LO, q[7:0]);
      rreg(`FREC_A_PTR_HI, q[15:8]);
      rreg(`FREC_A_PTR_UP, {2'b00, q[21:16]});
    end
    trial(8'hcc, 8'h33, 8'hc0, 5'h00, 6'h01, 8'he0);
    trial(8'h33, 8'hcc, 8'hc0, 5'h00, 6'h00, 8'hc0);
    trial(8'h55, 8'haa, 8'hc0, 5'h00, 6'h00, 8'hc0);
    trial(8'hdd, 8'h22, 8'hc0, 5'h00, 6'h00, 8'hc0);
    trial(8'hbb, 8'h44, 8'hc0, 5'h00, 6'h00, 8'hc0);
    trial(8'hcc, 8'h33, 8'hc0, 5'h01, 6'h00, 8'hc0);
    trial(8'hcc, 8'h33, 8'hc0, 5'h02, 6'h00, 8'hc0);
    trial(8'hcc, 8'h33, 8'hc0, 5'h04, 6'h00, 8'hc0);
    trial(8'hcc, 8'h5a, 8'hc0, 5'h00, 6'h00, 8'hc0);
    trial(8'hcc, 8'h33, 8'h40, 5'h00, 6'h00, 8'h40);
    trial(8'hcc, 8'h33, 8'hc0, 5'h08, 6'h00, 8'hd0);
    trial(8'hcc, 8'h33, 8'hc0, 5'h00, 6'h02, 8'hd0);
    trial(8'hcc, 8'h33, 8'hc0, 5'h10, 6'h00, 8'hd0);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
